//--- icc_pkg.sv
// Constants shared by the input capture channel and its buffer.
// Assumes one system clock and a plain register port.
package icc_pkg;
  localparam int ICC_DATA_W = 16;
  localparam int ICC_DEPTH = 4;
  localparam int ICC_PTR_W = 2;
  localparam logic [1:0] ICC_ADDR_CTRL = 2'h0;
  localparam logic [1:0] ICC_ADDR_BUF = 2'h1;
  localparam int ICC_BIT_SIDL = 13;
  localparam int ICC_BIT_TMR = 7;
  localparam int ICC_BIT_ICI_LO = 5;
  localparam int ICC_BIT_OV = 4;
  localparam int ICC_BIT_BNE = 3;
  localparam int ICC_BIT_MODE_LO = 0;
  localparam logic [2:0] ICC_MODE_OFF = 3'h0;
  localparam logic [2:0] ICC_MODE_EVERY = 3'h1;
  localparam logic [2:0] ICC_MODE_FALL = 3'h2;
  localparam logic [2:0] ICC_MODE_RISE = 3'h3;
  localparam logic [2:0] ICC_MODE_PRE4 = 3'h4;
  localparam logic [2:0] ICC_MODE_PRE16 = 3'h5;
  localparam logic [2:0] ICC_MODE_UNUSED = 3'h6;
  localparam logic [2:0] ICC_MODE_WAKE = 3'h7;
  localparam logic [3:0] ICC_PRE4_LAST = 4'h3;
  localparam logic [3:0] ICC_PRE16_LAST = 4'hf;
  localparam logic [15:0] ICC_CTRL_RESET = 16'h0000;
endpackage : icc_pkg

//--- icc_fifo_mem.sv
// Four-word storage for captured values, read data registered.
// Assumes the caller keeps pointers and never writes when full.
`timescale 1ns/1ps
module icc_fifo_mem
(
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [icc_pkg::ICC_PTR_W-1:0] wr_addr,
  input wire logic [icc_pkg::ICC_DATA_W-1:0] wr_data,
  input wire logic [icc_pkg::ICC_PTR_W-1:0] rd_addr,
  output logic [icc_pkg::ICC_DATA_W-1:0] rd_data
);
  import icc_pkg::*;
  logic [ICC_DATA_W-1:0] mem_q [ICC_DEPTH];

  // Storage and registered read, no reset needed for data
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
    rd_data <= mem_q[rd_addr];
  end
endmodule : icc_fifo_mem

//--- icc_channel.sv
// Input capture channel: edge detect, prescaler, four-word FIFO, control reg.
// Assumes pin and timer counts are synchronous to clk_sys; reg port is plain.
//
// Contract
// - Capture selected timer count on qualifying event
// - Timebase bit one picks second timer
// - Interrupt every one to four captures
// - Four-word FIFO, oldest value read first
// - Read-only overflow flag set by hardware
// - Buffer-not-empty bit reflects unread values
// - Modes 001 any, 010 fall, 011 rise
// - Modes 100/101 capture every 4th/16th rise
// - Every-edge mode ignores interrupt count field
// - Mode 111 rising edge wake only
// - Modes 000 and 110 perform no captures
// - Stop-in-idle halts channel in Idle
// - Pin event wakes from Sleep and Idle
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module icc_channel
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic capture_input_pin,
  input wire logic [icc_pkg::ICC_DATA_W-1:0] second_timer_count,
  input wire logic [icc_pkg::ICC_DATA_W-1:0] third_timer_count,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic [1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic capture_irq,
  output logic dma_req,
  output logic wake_req
);
  import icc_pkg::*;

  typedef enum logic [2:0]
  {
    ICC_RD_CTRL = 3'b001,
    ICC_RD_BUF = 3'b010,
    ICC_RD_NONE = 3'b100
  } icc_rdsel_t;

  typedef struct packed
  {
    logic sidl;
    logic tmr_sel;
    logic [1:0] ici;
    logic ov;
    logic [2:0] mode;
    logic pin_prev;
    logic [3:0] pre_cnt;
    logic [1:0] irq_cnt;
    logic [ICC_PTR_W-1:0] wr_ptr;
    logic [ICC_PTR_W-1:0] rd_ptr;
    logic [ICC_PTR_W:0] count;
    icc_rdsel_t rdsel;
    logic [15:0] ctrl_snap;
    logic irq;
    logic dma;
    logic wake;
  } icc_state_t;

  icc_state_t st_q;
  icc_state_t st_d;
  logic rise;
  logic fall;
  logic active;
  logic event_hit;
  logic full;
  logic push;
  logic pop;
  logic [ICC_DATA_W-1:0] cap_value;
  logic [ICC_DATA_W-1:0] mem_rdata;

  // Control word layout, used for reads and snapshot
  function automatic logic [15:0] icc_ctrl_word(input icc_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[ICC_BIT_SIDL] = s.sidl;
    w[ICC_BIT_TMR] = s.tmr_sel;
    w[ICC_BIT_ICI_LO +: 2] = s.ici;
    w[ICC_BIT_OV] = s.ov;
    w[ICC_BIT_BNE] = (s.count != '0);
    w[ICC_BIT_MODE_LO +: 3] = s.mode;
    return w;
  endfunction : icc_ctrl_word

  // Edge detection on the synchronous pin
  assign rise = capture_input_pin & ~st_q.pin_prev;
  assign fall = ~capture_input_pin & st_q.pin_prev;

  // Halted in Idle when stop-in-idle set; captures and prescaler frozen in Sleep
  assign active = ~cpu_sleep & ~(cpu_idle & st_q.sidl);

  // Event qualification per mode
  always_comb
  begin
    event_hit = 1'b0;
    unique case (st_q.mode)
      ICC_MODE_EVERY: event_hit = rise | fall;
      ICC_MODE_FALL: event_hit = fall;
      ICC_MODE_RISE: event_hit = rise;
      ICC_MODE_PRE4: event_hit = rise && (st_q.pre_cnt[1:0] == ICC_PRE4_LAST[1:0]);
      ICC_MODE_PRE16: event_hit = rise && (st_q.pre_cnt == ICC_PRE16_LAST);
      ICC_MODE_OFF, ICC_MODE_UNUSED, ICC_MODE_WAKE: event_hit = 1'b0;
    endcase
  end

  // Time base choice: one is the second timer
  assign cap_value = st_q.tmr_sel ? second_timer_count : third_timer_count;
  // Count is one bit wider than the pointers, so full and empty stay distinct
  assign full = (st_q.count == (ICC_PTR_W + 1)'(ICC_DEPTH)) ? 1'b1 : 1'b0;
  assign push = active & event_hit & ~full;
  // Pop on buffer read; empty reads leave pointers alone
  assign pop = reg_rd && (reg_addr == ICC_ADDR_BUF) && (st_q.count != '0);

  // Next-state logic for the whole channel
  always_comb
  begin
    st_d = st_q;
    st_d.irq = 1'b0;
    st_d.dma = 1'b0;
    st_d.wake = 1'b0;
    st_d.pin_prev = capture_input_pin;
    // Prescaler counts rises only in prescaled modes, cleared otherwise
    if ((st_q.mode == ICC_MODE_PRE4) || (st_q.mode == ICC_MODE_PRE16))
    begin
      if (active && rise)
      begin
        st_d.pre_cnt = st_q.pre_cnt + 4'h1;
      end
    end
    else
    begin
      st_d.pre_cnt = 4'h0;
    end
    // FIFO bookkeeping
    if (push)
    begin
      st_d.wr_ptr = st_q.wr_ptr + 2'h1;
    end
    if (pop)
    begin
      st_d.rd_ptr = st_q.rd_ptr + 2'h1;
    end
    st_d.count = st_q.count + {2'h0, push} - {2'h0, pop};
    // Interrupt rate; every-edge mode interrupts each capture
    if (push)
    begin
      st_d.dma = 1'b1;
      if ((st_q.mode == ICC_MODE_EVERY) || (st_q.irq_cnt == st_q.ici))
      begin
        st_d.irq = 1'b1;
        st_d.irq_cnt = 2'h0;
      end
      else
      begin
        st_d.irq_cnt = st_q.irq_cnt + 2'h1;
      end
    end
    // Wake pulse: mode 111 rises, or any qualifying event, while asleep or idle
    if ((cpu_sleep || cpu_idle) && ((st_q.mode == ICC_MODE_WAKE) ? rise : event_hit))
    begin
      st_d.wake = 1'b1;
      if (st_q.mode == ICC_MODE_WAKE)
      begin
        st_d.irq = 1'b1;
      end
    end
    // Register write: overflow and buffer bits are read-only
    if (reg_wr && (reg_addr == ICC_ADDR_CTRL))
    begin
      st_d.sidl = reg_wdata[ICC_BIT_SIDL];
      st_d.tmr_sel = reg_wdata[ICC_BIT_TMR];
      st_d.ici = reg_wdata[ICC_BIT_ICI_LO +: 2];
      st_d.mode = reg_wdata[ICC_BIT_MODE_LO +: 3];
      st_d.irq_cnt = 2'h0; // Restart the interrupt group on reconfig
      // Turning off empties the buffer and clears overflow
      if (reg_wdata[ICC_BIT_MODE_LO +: 3] == ICC_MODE_OFF)
      begin
        st_d.wr_ptr = '0;
        st_d.rd_ptr = '0;
        st_d.count = '0;
        st_d.ov = 1'b0;
      end
    end
    // Overflow after the write, so a capture into a full buffer beats any clear
    if (active && event_hit && full)
    begin
      st_d.ov = 1'b1;
    end
    else if (st_q.ov && pop)
    begin
      st_d.ov = 1'b0;
    end
    // Read select for the next cycle
    st_d.rdsel = ICC_RD_NONE;
    st_d.ctrl_snap = icc_ctrl_word(st_q);
    if (reg_rd)
    begin
      if (reg_addr == ICC_ADDR_CTRL)
      begin
        st_d.rdsel = ICC_RD_CTRL;
      end
      else if (reg_addr == ICC_ADDR_BUF)
      begin
        st_d.rdsel = ICC_RD_BUF;
      end
    end
  end

  // Buffer storage, read address is the oldest entry
  icc_fifo_mem u_mem
  (
    .clk_sys(clk_sys),
    .wr_en(push),
    .wr_addr(st_q.wr_ptr),
    .wr_data(cap_value),
    .rd_addr(st_q.rd_ptr),
    .rd_data(mem_rdata)
  );

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_q <= '{sidl: 1'b0, tmr_sel: 1'b0, ici: 2'h0, ov: 1'b0, mode: ICC_MODE_OFF,
                pin_prev: 1'b0, pre_cnt: 4'h0, irq_cnt: 2'h0, wr_ptr: '0, rd_ptr: '0,
                count: '0, rdsel: ICC_RD_NONE, ctrl_snap: ICC_CTRL_RESET,
                irq: 1'b0, dma: 1'b0, wake: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb
  begin
    unique case (st_q.rdsel)
      ICC_RD_CTRL: reg_rdata = st_q.ctrl_snap;
      ICC_RD_BUF: reg_rdata = mem_rdata;
      ICC_RD_NONE: reg_rdata = 16'h0000;
      default: reg_rdata = 16'h0000;
    endcase
  end

  assign capture_irq = st_q.irq;
  assign dma_req = st_q.dma;
  assign wake_req = st_q.wake;

  // Helpers for checks
  logic past_valid_q;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      past_valid_q <= 1'b0;
    end
    else
    begin
      past_valid_q <= 1'b1;
    end
  end

  // Rule checks, all disabled while reset is high
  a_capture_push: assert property (@(posedge clk_sys) disable iff (reset)
    push |=> st_q.wr_ptr == $past(st_q.wr_ptr) + 2'h1)
    else $error("capture did not advance write pointer");
  a_timebase_sel: assert property (@(posedge clk_sys) disable iff (reset)
    push && st_q.tmr_sel |-> cap_value == second_timer_count)
    else $error("wrong timer captured");
  a_every_irq: assert property (@(posedge clk_sys) disable iff (reset)
    push && st_q.mode == ICC_MODE_EVERY && !(reg_wr && reg_addr == ICC_ADDR_CTRL)
    |=> capture_irq)
    else $error("every-edge capture missed interrupt");
  a_ici_rate: assert property (@(posedge clk_sys) disable iff (reset)
    push && st_q.mode != ICC_MODE_EVERY && st_q.irq_cnt != st_q.ici && !cpu_sleep
    && !cpu_idle |=> !capture_irq)
    else $error("interrupt before group complete");
  a_irq_source: assert property (@(posedge clk_sys) disable iff (reset)
    capture_irq |-> $past(push) || $past(st_q.mode) == ICC_MODE_WAKE)
    else $error("interrupt without capture");
  a_overflow_set: assert property (@(posedge clk_sys) disable iff (reset)
    active && event_hit && full |=> st_q.ov)
    else $error("overflow not flagged");
  a_overflow_drop: assert property (@(posedge clk_sys) disable iff (reset)
    active && event_hit && full && !(reg_wr && reg_addr == ICC_ADDR_CTRL)
    |=> st_q.count == 3'h4 - {2'h0, $past(pop)})
    else $error("overflowing value was stored");
  // Software cannot clear the flag, only a pop or turning the channel off
  a_ov_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    st_q.ov && !pop && !(reg_wr && reg_addr == ICC_ADDR_CTRL
    && reg_wdata[ICC_BIT_MODE_LO +: 3] == ICC_MODE_OFF) |=> st_q.ov)
    else $error("overflow flag lost");
  // Status read back compared with the pointers, not with the count
  a_bne_status: assert property (@(posedge clk_sys) disable iff (reset)
    past_valid_q && $past(reg_rd && reg_addr == ICC_ADDR_CTRL)
    |-> reg_rdata[ICC_BIT_BNE] == $past((st_q.wr_ptr != st_q.rd_ptr) || full))
    else $error("buffer status wrong");
  a_ptr_full: assert property (@(posedge clk_sys) disable iff (reset)
    full |-> st_q.wr_ptr == st_q.rd_ptr)
    else $error("full buffer with pointers apart");
  a_off_nocap: assert property (@(posedge clk_sys) disable iff (reset)
    st_q.mode == ICC_MODE_OFF || st_q.mode == ICC_MODE_UNUSED |-> !push)
    else $error("capture while disabled");
  a_reset_quiet: assert property (@(posedge clk_sys) disable iff (reset)
    $past(reset) |-> !capture_irq && !dma_req && !wake_req && st_q.mode == ICC_MODE_OFF)
    else $error("channel not quiet after reset");
  a_idle_halt: assert property (@(posedge clk_sys) disable iff (reset)
    cpu_idle && st_q.sidl |-> !push)
    else $error("capture while halted in idle");
  a_wake_rise: assert property (@(posedge clk_sys) disable iff (reset)
    st_q.mode == ICC_MODE_WAKE && cpu_sleep && rise |=> wake_req && capture_irq)
    else $error("wake-only mode missed rise");
  a_wake_event: assert property (@(posedge clk_sys) disable iff (reset)
    (cpu_sleep || cpu_idle) && st_q.mode == ICC_MODE_RISE && rise |=> wake_req)
    else $error("pin event did not wake");
  a_pop_read: assert property (@(posedge clk_sys) disable iff (reset)
    pop && !push |=> st_q.count == $past(st_q.count) - 3'h1)
    else $error("read did not pop");

  // Scenario covers
  c_fill_full: cover property (@(posedge clk_sys) disable iff (reset) full);
  c_group_irq: cover property (@(posedge clk_sys) disable iff (reset)
    push && st_q.ici == 2'h3 && st_q.irq_cnt == 2'h3);
  c_overflow: cover property (@(posedge clk_sys) disable iff (reset) st_q.ov);
  c_pre16: cover property (@(posedge clk_sys) disable iff (reset)
    push && st_q.mode == ICC_MODE_PRE16);
  c_wake: cover property (@(posedge clk_sys) disable iff (reset) wake_req);
endmodule : icc_channel

//--- icc_pin_src.sv
// Signal source model that drives the capture pin with bursts of edges.
// Assumes one clk_sys domain; the pin idles low between bursts.
`timescale 1ns/1ps
module icc_pin_src
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic go,
  input wire logic [5:0] n_edges,
  output logic capture_input_pin,
  output logic busy
);
  logic [5:0] left_q;
  logic ph_q;
  assign busy = (left_q != 6'h00);
  // Two cycles per level keeps every edge visible to a sync sampler
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      left_q <= 6'h00;
      ph_q <= 1'b0;
      capture_input_pin <= 1'b0;
    end
    else if (go && !busy)
    begin
      left_q <= n_edges;
      ph_q <= 1'b0;
    end
    else if (busy)
    begin
      ph_q <= ~ph_q;
      if (ph_q)
      begin
        capture_input_pin <= ~capture_input_pin;
        left_q <= left_q - 6'h01;
      end
    end
  end
endmodule : icc_pin_src

//--- icc_channel_tb.sv
// Self-checking bench for the capture channel: register tasks plus pin bursts.
// Assumes the pin source model and the channel share clk_sys.
`timescale 1ns/1ps
module icc_channel_tb;
  import icc_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, pin, cpu_idle = 1'b0, cpu_sleep = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, busy, capture_irq, dma_req, wake_req;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, second_timer_count = 16'h0000;
  logic [15:0] third_timer_count = 16'h0000, reg_rdata;
  logic [5:0] n_edges = 6'h00;
  int n_errors = 0, cmp_count = 0, n_irq = 0, n_dma = 0, n_wake = 0, cyc = 0, i0, d0, w0;
  always #20 clk_sys = ~clk_sys;
  // Event tallies and a hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    n_irq += (capture_irq === 1'b1);
    n_dma += (dma_req === 1'b1);
    n_wake += (wake_req === 1'b1);
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  icc_channel dut (.clk_sys(clk_sys), .reset(reset), .capture_input_pin(pin),
    .second_timer_count(second_timer_count), .third_timer_count(third_timer_count),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_irq(capture_irq),
    .dma_req(dma_req), .wake_req(wake_req));
  icc_pin_src src (.clk_sys(clk_sys), .reset(reset), .go(go), .n_edges(n_edges),
    .capture_input_pin(pin), .busy(busy));
  task automatic report_and_stop();
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [15:0] exp, input string name);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(name, reg_rdata, exp);
  endtask : rd
  // Burst of n pin edges, then time for the capture pipeline to settle
  task automatic pulse(input logic [5:0] n);
    int k;
    @(posedge clk_sys);
    n_edges <= n;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    #1;
    for (k = 0; k < 200 && busy !== 1'b0; k++)
      @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : pulse
  function automatic logic [15:0] ctl(input logic s, input logic t, input logic [1:0] i,
    input logic [2:0] m);
    return {2'h0, s, 5'h00, t, i, 2'h0, m};
  endfunction : ctl
  logic [2:0] modes [2];
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd(ICC_ADDR_CTRL, 16'h0000, "ctrl_reset");
    rd(2'h2, 16'h0000, "unmapped");
    // Fill past depth with the second timer selected
    wr(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_RISE));
    for (int k = 0; k < 5; k++)
    begin
      second_timer_count <= 16'h1000 + 16'(k);
      third_timer_count <= 16'h2000 + 16'(k);
      pulse(6'd2);
    end
    rd(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_RISE) | 16'h0018, "ctrl_full");
    // A software write with the flag bit low must not clear it
    wr(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_RISE));
    rd(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_RISE) | 16'h0018, "ov_kept");
    for (int k = 0; k < 4; k++)
      rd(ICC_ADDR_BUF, 16'h1000 + 16'(k), "buf_order");
    rd(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_RISE), "ctrl_drained");
    // Falling edge only, third timer; then both edges with the count field ignored
    wr(ICC_ADDR_CTRL, ctl(0, 0, 0, ICC_MODE_FALL));
    third_timer_count <= 16'h4444;
    d0 = n_dma;
    pulse(6'd2);
    chk("fall_count", 16'(n_dma - d0), 16'h0001);
    rd(ICC_ADDR_BUF, 16'h4444, "fall_value");
    wr(ICC_ADDR_CTRL, ctl(0, 0, 3, ICC_MODE_EVERY));
    i0 = n_irq;
    pulse(6'd2);
    chk("every_irq", 16'(n_irq - i0), 16'h0002);
    rd(ICC_ADDR_BUF, 16'h4444, "every_value");
    // Interrupt rate for every count field setting
    for (int i = 0; i < 4; i++)
    begin
      wr(ICC_ADDR_CTRL, ctl(0, 1, 2'(i), ICC_MODE_OFF));
      wr(ICC_ADDR_CTRL, ctl(0, 1, 2'(i), ICC_MODE_RISE));
      i0 = n_irq;
      d0 = n_dma;
      pulse(6'd8);
      chk("irq_rate", 16'(n_irq - i0), 16'(4 / (i + 1)));
      chk("dma_each", 16'(n_dma - d0), 16'h0004);
    end
    // Prescalers: one short of a group, then the completing rise
    modes[0] = ICC_MODE_PRE4;
    modes[1] = ICC_MODE_PRE16;
    for (int p = 0; p < 2; p++)
    begin
      wr(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_OFF));
      wr(ICC_ADDR_CTRL, ctl(0, 1, 0, modes[p]));
      d0 = n_dma;
      pulse(p == 0 ? 6'd6 : 6'd30);
      chk("pre_short", 16'(n_dma - d0), 16'h0000);
      pulse(6'd2);
      chk("pre_group", 16'(n_dma - d0), 16'h0001);
    end
    // Disabled modes take nothing
    modes[0] = ICC_MODE_OFF;
    modes[1] = ICC_MODE_UNUSED;
    for (int p = 0; p < 2; p++)
    begin
      wr(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_OFF));
      wr(ICC_ADDR_CTRL, ctl(0, 1, 0, modes[p]));
      d0 = n_dma;
      pulse(6'd4);
      chk("off_dma", 16'(n_dma - d0), 16'h0000);
      rd(ICC_ADDR_CTRL, ctl(0, 1, 0, modes[p]), "off_ctrl");
    end
    // Idle: halted with stop bit set, running and waking with it clear
    cpu_idle <= 1'b1;
    wr(ICC_ADDR_CTRL, ctl(1, 1, 0, ICC_MODE_RISE));
    d0 = n_dma;
    pulse(6'd2);
    chk("idle_stop", 16'(n_dma - d0), 16'h0000);
    wr(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_RISE));
    w0 = n_wake;
    pulse(6'd2);
    chk("idle_run", 16'(n_dma - d0), 16'h0001);
    chk("idle_wake", 16'(n_wake - w0), 16'h0001);
    cpu_idle <= 1'b0;
    // Sleep with the pin as a rising-edge wake source only
    cpu_sleep <= 1'b1;
    wr(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_OFF));
    wr(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_WAKE));
    w0 = n_wake;
    d0 = n_dma;
    pulse(6'd2);
    chk("sleep_wake", 16'(n_wake - w0), 16'h0001);
    chk("sleep_nocap", 16'(n_dma - d0), 16'h0000);
    cpu_sleep <= 1'b0;
    // Status bits ignore software writes
    wr(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_OFF) | 16'h0018);
    rd(ICC_ADDR_CTRL, ctl(0, 1, 0, ICC_MODE_OFF), "ro_bits");
    report_and_stop();
  end
endmodule : icc_channel_tb
